// *** afw_pkg.sv ***
// Package of the converter flag, watchdog and result alignment block.
// Assumes one clock domain; shared by the top and its result store.
package afw_pkg;
  localparam int unsigned      DATA_W        = 10;      // Converter result width
  localparam int unsigned      ENTRY_N       = 10;      // Largest buffer or channel count
  localparam int unsigned      IDX_W         = 4;       // Entry index width
  localparam int unsigned      BYTE_W        = 8;       // Result byte width
  localparam logic [IDX_W-1:0] DEPTH_SMALL   = 4'h8;    // Buffer depth, small variant
  localparam logic [IDX_W-1:0] DEPTH_LARGE   = 4'ha;    // Buffer depth, large variant
  localparam logic [ENTRY_N-1:0] STATUS_RST  = 10'h000; // Status bits after reset
  localparam logic [BYTE_W-1:0] BYTE_RST     = 8'h00;   // Result bytes after reset
  localparam logic [DATA_W-1:0] DATA_RST     = 10'h000; // Stored results after reset
  localparam int unsigned      LEFT_LOW_BITS = DATA_W - BYTE_W; // Bits left for low byte

  // Operating mode decoded from the mode inputs
  typedef enum logic [1:0] {
    AFW_MODE_OFF  = 2'b00,
    AFW_MODE_BUF  = 2'b01,
    AFW_MODE_SCAN = 2'b10
  } afw_mode_t;
endpackage

// *** afw_result_store.sv ***
// Result store: one word per buffer entry or scan channel, registered read.
// Assumes writes and reads are on the same clock; read data lags one cycle.
`timescale 1ns/1ns
`default_nettype none
module afw_result_store (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  // Write side
  input  wire logic                       wr_en,
  input  wire logic [afw_pkg::IDX_W-1:0]  wr_idx,
  input  wire logic [afw_pkg::DATA_W-1:0] wr_data,
  // Read side
  input  wire logic [afw_pkg::IDX_W-1:0]  rd_idx,
  output var  logic [afw_pkg::DATA_W-1:0] rd_data
);
  import afw_pkg::*;

  logic [DATA_W-1:0] mem_ff [ENTRY_N];
  logic [DATA_W-1:0] nxt_rd_data;

  // Out-of-range index reads zero rather than an undefined word
  always_comb begin
    nxt_rd_data = DATA_RST;
    if (rd_idx < IDX_W'(ENTRY_N)) begin
      nxt_rd_data = mem_ff[rd_idx];
    end
  end

  // Storage and read register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < ENTRY_N; i++) begin
        mem_ff[i] <= DATA_RST;
      end
      rd_data <= DATA_RST;
    end else begin
      if (wr_en && (wr_idx < IDX_W'(ENTRY_N))) begin
        mem_ff[wr_idx] <= wr_data;
      end
      rd_data <= nxt_rd_data;
    end
  end
endmodule // afw_result_store
`default_nettype wire

// *** afw_flag_align.sv ***
// Flag, watchdog, interrupt and alignment logic of a 10-bit converter.
// Assumes conversion results arrive as one-cycle pulses on mclk from the
// converter core, and software clear strobes come from the register logic.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Buffered mode sets done flag after full buffer; interrupt only if enabled.
// - Buffered mode sets entry status on window crossing when checking enabled.
// - Watchdog interrupt disabled: global flag set at buffer end, no interrupt.
// - Watchdog irq only: flag and interrupt at buffer end, conversion continues.
// - Both enables set: flag immediately on status, interrupt, stop conversion.
// - Scan mode sets done flag at sequence end; interrupt only if enabled.
// - Scan mode sets channel status on window crossing when checking enabled.
// - Scan, watchdog irq disabled: global flag at sequence end, no interrupt.
// - Scan, watchdog irq only: flag and interrupt at sequence end, keep scanning.
// - Scan, both enables: flag immediately, interrupt, halt the scan.
// - Converter interrupts wake the core from Wait, never from Halt.
// - Software alignment select chooses left or right aligned result bytes.
// - Right alignment: low eight bits in low byte, rest low in high byte.
// - Left alignment: high eight bits in high byte, rest top of low byte.
// - Buffer depth is 8 or 10 entries by variant.
module afw_flag_align (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  // Mode and configuration
  input  wire logic                        buffered_mode,
  input  wire logic                        scan_mode,
  input  wire logic                        buffer_depth,
  input  wire logic                        align_left,
  input  wire logic                        conversion_done_irq_enable,
  input  wire logic                        watchdog_irq_enable,
  input  wire logic [afw_pkg::ENTRY_N-1:0] watchdog_channel_enable,
  input  wire logic [afw_pkg::DATA_W-1:0]  high_threshold,
  input  wire logic [afw_pkg::DATA_W-1:0]  low_threshold,
  // Conversion results from the converter core
  input  wire logic                        conv_valid,
  input  wire logic [afw_pkg::IDX_W-1:0]   conv_index,
  input  wire logic [afw_pkg::DATA_W-1:0]  conv_data,
  input  wire logic                        scan_last,
  // Software clear strobes
  input  wire logic                        done_clear,
  input  wire logic                        watchdog_clear,
  input  wire logic [afw_pkg::ENTRY_N-1:0] status_clear,
  // Result readout
  input  wire logic [afw_pkg::IDX_W-1:0]   read_index,
  input  wire logic                        read_low_strobe,
  input  wire logic                        read_high_strobe,
  output var  logic [afw_pkg::BYTE_W-1:0]  result_high_byte,
  output var  logic [afw_pkg::BYTE_W-1:0]  result_low_byte,
  // Flags and requests
  output var  logic                        conversion_done_flag,
  output var  logic                        global_watchdog_flag,
  output var  logic [afw_pkg::ENTRY_N-1:0] channel_watchdog_status,
  output var  logic                        stop_conversion,
  output logic                             irq_request,
  output logic                             wake_from_wait,
  output logic                             wake_from_halt
);
  import afw_pkg::*;

  afw_mode_t             mode;
  logic                  active;
  logic                  out_of_window;
  logic [ENTRY_N-1:0]    hit_vec;
  logic                  any_hit;
  logic                  complete;
  logic [IDX_W-1:0]      depth;
  logic                  immediate;
  logic [DATA_W-1:0]     rd_data;
  logic [BYTE_W-1:0]     aligned_high;
  logic [BYTE_W-1:0]     aligned_low;
  logic                  first_strobe;
  logic                  second_strobe;
  logic                  nxt_done;
  logic                  nxt_wdg;
  logic                  nxt_stop;
  logic                  nxt_locked;
  logic                  locked_ff;
  logic [ENTRY_N-1:0]    nxt_status;
  logic [BYTE_W-1:0]     nxt_high;
  logic [BYTE_W-1:0]     nxt_low;

  // Mode decode; scan takes priority if both inputs are high
  always_comb begin
    if (scan_mode) begin
      mode = AFW_MODE_SCAN;
    end else if (buffered_mode) begin
      mode = AFW_MODE_BUF;
    end else begin
      mode = AFW_MODE_OFF;
    end
  end
  assign active = (mode != AFW_MODE_OFF);

  assign depth = buffer_depth ? DEPTH_LARGE : DEPTH_SMALL;

  always_comb begin
    unique case (mode)
      AFW_MODE_BUF:  complete = conv_valid && (conv_index == depth - 4'h1);
      AFW_MODE_SCAN: complete = conv_valid && scan_last;
      AFW_MODE_OFF:  complete = 1'b0;
      default:       complete = 1'b0;
    endcase
  end

  assign out_of_window = (conv_data > high_threshold) || (conv_data < low_threshold);
  always_comb begin
    hit_vec = STATUS_RST;
    if (active && conv_valid && out_of_window && (conv_index < IDX_W'(ENTRY_N))) begin
      hit_vec[conv_index] = watchdog_channel_enable[conv_index];
    end
  end
  assign any_hit = |hit_vec;

  // Both enables set selects the immediate, stopping watchdog behaviour
  assign immediate = watchdog_irq_enable && conversion_done_irq_enable;

  // Flag next values; a hardware set always beats a clear in the same cycle
  always_comb begin
    nxt_status = (channel_watchdog_status & ~status_clear) | hit_vec;
    nxt_done = (conversion_done_flag && !done_clear) || complete;
    nxt_wdg  = global_watchdog_flag && !watchdog_clear;
    nxt_stop = stop_conversion && !watchdog_clear && active;
    if (immediate) begin
      if (any_hit) begin
        nxt_wdg  = 1'b1;
        nxt_stop = 1'b1;
      end
    end else if (complete && (|(channel_watchdog_status | hit_vec))) begin
      nxt_wdg = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_watchdog_status <= STATUS_RST;
      conversion_done_flag    <= 1'b0;
      global_watchdog_flag    <= 1'b0;
      stop_conversion         <= 1'b0;
    end else begin
      channel_watchdog_status <= nxt_status;
      conversion_done_flag    <= nxt_done;
      global_watchdog_flag    <= nxt_wdg;
      stop_conversion         <= nxt_stop;
    end
  end

  // converter interrupt
  // Level request held while the converter is active, until software clears the flag that caused it
  assign irq_request = active && ((conversion_done_flag && conversion_done_irq_enable) ||
                                  (global_watchdog_flag && watchdog_irq_enable));
  assign wake_from_wait = irq_request;
  assign wake_from_halt = 1'b0;

  // Results are stored per entry so every buffer slot stays readable
  afw_result_store u_store (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .wr_en   (conv_valid && active),
    .wr_idx  (conv_index),
    .wr_data (conv_data),
    .rd_idx  (read_index),
    .rd_data (rd_data)
  );

  always_comb begin
    if (align_left) begin
      aligned_high = rd_data[DATA_W-1 -: BYTE_W];
      aligned_low  = {rd_data[LEFT_LOW_BITS-1:0], {(BYTE_W-LEFT_LOW_BITS){1'b0}}};
    end else begin
      aligned_high = {{(2*BYTE_W-DATA_W){1'b0}}, rd_data[DATA_W-1:BYTE_W]};
      aligned_low  = rd_data[BYTE_W-1:0];
    end
  end

  assign first_strobe  = align_left ? read_high_strobe : read_low_strobe;
  assign second_strobe = align_left ? read_low_strobe  : read_high_strobe;

  // byte lock
  // Without the lock a conversion between the two reads could mix two results
  always_comb begin
    nxt_locked = locked_ff;
    nxt_high   = result_high_byte;
    nxt_low    = result_low_byte;
    if (locked_ff) begin
      if (second_strobe) begin
        nxt_locked = 1'b0;
      end
    end else begin
      nxt_high = aligned_high;
      nxt_low  = aligned_low;
      if (first_strobe) begin
        nxt_locked = 1'b1;
        nxt_high   = result_high_byte; // Keep what the first read saw
        nxt_low    = result_low_byte;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      locked_ff        <= 1'b0;
      result_high_byte <= BYTE_RST;
      result_low_byte  <= BYTE_RST;
    end else begin
      locked_ff        <= nxt_locked;
      result_high_byte <= nxt_high;
      result_low_byte  <= nxt_low;
    end
  end
endmodule // afw_flag_align
`default_nettype wire

// *** afw_flag_align_properties.sv ***
// Checker of the flag, watchdog and alignment block's port behaviour.
// Assumes enables stay steady while conversions run.
`timescale 1ns/1ns
`default_nettype none
module afw_flag_align_properties (
  // Clock, reset, mode
  input wire logic                      mclk,
  input wire logic                      sys_rst,
  input wire logic                      buffered_mode,
  input wire logic                      scan_mode,
  input wire logic                      buffer_depth,
  input wire logic                      align_left,
  input wire logic                      conversion_done_irq_enable,
  input wire logic                      watchdog_irq_enable,
  // Conversions and reads
  input wire logic                      conv_valid,
  input wire logic [afw_pkg::IDX_W-1:0] conv_index,
  input wire logic                      scan_last,
  input wire logic                      read_low_strobe,
  input wire logic                      read_high_strobe,
  // Design outputs
  input wire logic [afw_pkg::BYTE_W-1:0]  result_high_byte,
  input wire logic                        conversion_done_flag,
  input wire logic                        global_watchdog_flag,
  input wire logic [afw_pkg::ENTRY_N-1:0] channel_watchdog_status,
  input wire logic                        stop_conversion,
  input wire logic                        irq_request,
  input wire logic                        wake_from_wait,
  input wire logic                        wake_from_halt
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_wake; wake_from_wait == irq_request; endproperty
  a_wake: assert property (p_wake) else $error("wait wake differs from irq");
  property p_halt; !wake_from_halt; endproperty
  a_halt: assert property (p_halt) else $error("halt wake raised");
  // No request while the converter is idle, whatever flags remain
  property p_irq; irq_request == ((buffered_mode || scan_mode)
    && ((conversion_done_flag && conversion_done_irq_enable)
    || (global_watchdog_flag && watchdog_irq_enable))); endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_done_buf; buffered_mode && !scan_mode && conv_valid
    && conv_index == (buffer_depth ? 4'h9 : 4'h7) |=> conversion_done_flag; endproperty
  a_done_buf: assert property (p_done_buf) else $error("buffer done missing");
  property p_done_scan; scan_mode && conv_valid && scan_last |=> conversion_done_flag;
  endproperty
  a_done_scan: assert property (p_done_scan) else $error("scan done missing");
  property p_stat; $rose(|channel_watchdog_status) |-> $past(conv_valid); endproperty
  a_stat: assert property (p_stat) else $error("status without conversion");
  property p_immed; watchdog_irq_enable && conversion_done_irq_enable
    && $rose(|channel_watchdog_status) |-> global_watchdog_flag && stop_conversion;
  endproperty
  a_immed: assert property (p_immed) else $error("immediate flag missing");
  property p_stop; $rose(stop_conversion) |->
    watchdog_irq_enable && conversion_done_irq_enable; endproperty
  a_stop: assert property (p_stop) else $error("stop without both enables");
  property p_late; !(watchdog_irq_enable && conversion_done_irq_enable)
    && $rose(global_watchdog_flag) |-> conversion_done_flag; endproperty
  a_late: assert property (p_late) else $error("watchdog flag before end");
  property p_hold; (!align_left && read_low_strobe) ##1 (!read_high_strobe)[*3]
    |-> $stable(result_high_byte); endproperty
  a_hold: assert property (p_hold) else $error("locked byte moved");
endmodule // afw_flag_align_properties
`default_nettype wire

// *** tb_top.sv ***
// Testbench of the flag, watchdog and alignment block.
// Assumes inputs move on the falling edge and fixed latencies.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
  import afw_pkg::*;
  // Inputs and outputs of the block
  logic mclk = 1'b0;
  logic sys_rst, buffered_mode, scan_mode, buffer_depth, align_left, scan_last;
  logic conversion_done_irq_enable, watchdog_irq_enable, conv_valid, done_clear;
  logic watchdog_clear, read_low_strobe, read_high_strobe, conversion_done_flag;
  logic global_watchdog_flag, stop_conversion, irq_request, wake_from_wait, wake_from_halt;
  logic [ENTRY_N-1:0] watchdog_channel_enable, status_clear, channel_watchdog_status;
  logic [DATA_W-1:0]  high_threshold, low_threshold, conv_data;
  logic [IDX_W-1:0]   conv_index, read_index;
  logic [BYTE_W-1:0]  result_high_byte, result_low_byte;
  int miscompares = 0;
  int samples_checked = 0;
  afw_flag_align u_afw_flag_align (.mclk, .sys_rst, .buffered_mode, .scan_mode,
    .buffer_depth, .align_left, .conversion_done_irq_enable, .watchdog_irq_enable,
    .watchdog_channel_enable, .high_threshold, .low_threshold, .conv_valid, .conv_index,
    .conv_data, .scan_last, .done_clear, .watchdog_clear, .status_clear, .read_index,
    .read_low_strobe, .read_high_strobe, .result_high_byte, .result_low_byte,
    .conversion_done_flag, .global_watchdog_flag, .channel_watchdog_status,
    .stop_conversion, .irq_request, .wake_from_wait, .wake_from_halt);
  // Clock
  always #5 mclk = ~mclk;
  // One conversion pulse; an idle cycle follows so back-to-back calls never
  // lower and raise the valid pulse in the same time step
  task automatic cv(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d, input logic l);
    conv_valid = 1'b1;
    conv_index = i;
    conv_data = d;
    scan_last = l;
    @(negedge mclk);
    conv_valid = 1'b0;
    scan_last = 1'b0;
    @(negedge mclk);
  endtask
  // Clear every flag as software would
  task automatic clr();
    done_clear = 1'b1;
    watchdog_clear = 1'b1;
    status_clear = 10'h3ff;
    @(negedge mclk);
    done_clear = 1'b0;
    watchdog_clear = 1'b0;
    status_clear = 10'h000;
    `CHK(irq_request, 1'b0)
  endtask
  // Buffered, depth ten, watchdog interrupt only
  task automatic t_buf();
    buffered_mode = 1'b1;
    for (int i = 0; i < 10; i++) begin
      cv(i[3:0], (i == 2 || i == 3) ? 10'h3ff : 10'h200, 1'b0);
      if (i == 3) `CHK({channel_watchdog_status, global_watchdog_flag}, 11'h008)
      if (i == 8) `CHK(conversion_done_flag, 1'b0)
    end
    `CHK({conversion_done_flag, global_watchdog_flag, irq_request}, 3'h7)
    `CHK(stop_conversion, 1'b0)
    clr();
    $display("t_buf finished");
  endtask
  // Scan with both enables, then at sequence end only
  task automatic t_scan();
    {buffered_mode, scan_mode, conversion_done_irq_enable} = 3'h3;
    watchdog_channel_enable = 10'h006;
    cv(4'h1, 10'h005, 1'b0); // Below the low threshold
    `CHK({global_watchdog_flag, stop_conversion, conversion_done_flag}, 3'h6)
    `CHK({wake_from_wait, wake_from_halt}, 2'h2)
    clr();
    watchdog_irq_enable = 1'b0;
    cv(4'h1, 10'h3ff, 1'b0);
    `CHK(global_watchdog_flag, 1'b0)
    cv(4'h4, 10'h200, 1'b1);
    `CHK({conversion_done_flag, global_watchdog_flag, irq_request}, 3'h7)
    clr();
    {conversion_done_irq_enable, watchdog_irq_enable} = 2'h1;
    cv(4'h3, 10'h3ff, 1'b0);
    `CHK(channel_watchdog_status, 10'h000)
    cv(4'h2, 10'h3ff, 1'b0);
    `CHK({global_watchdog_flag, irq_request}, 2'h0)
    cv(4'h5, 10'h200, 1'b1);
    `CHK({conversion_done_flag, global_watchdog_flag, irq_request, stop_conversion}, 4'he)
    clr();
    $display("t_scan finished");
  endtask
  // Result bytes in both alignments, and the read lock
  task automatic t_align();
    cv(4'h5, 10'h2d5, 1'b0);
    read_index = 4'h5;
    repeat (3) @(negedge mclk);
    `CHK({result_high_byte, result_low_byte}, 16'h02d5)
    align_left = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK({result_high_byte, result_low_byte}, 16'hb540)
    align_left = 1'b0;
    repeat (3) @(negedge mclk);
    read_low_strobe = 1'b1;
    @(negedge mclk);
    read_low_strobe = 1'b0;
    cv(4'h5, 10'h12a, 1'b0);
    repeat (3) @(negedge mclk);
    `CHK({result_high_byte, result_low_byte}, 16'h02d5)
    read_high_strobe = 1'b1;
    @(negedge mclk);
    read_high_strobe = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK({result_high_byte, result_low_byte}, 16'h012a)
    align_left = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK({result_high_byte, result_low_byte}, 16'h4a80)
    read_high_strobe = 1'b1;
    @(negedge mclk);
    read_high_strobe = 1'b0;
    cv(4'h5, 10'h2d5, 1'b0);
    repeat (3) @(negedge mclk);
    `CHK({result_high_byte, result_low_byte}, 16'h4a80)
    read_low_strobe = 1'b1;
    @(negedge mclk);
    read_low_strobe = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK({result_high_byte, result_low_byte}, 16'hb540)
    $display("t_align finished");
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard: a run past this bound is a failure
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {buffered_mode, scan_mode, align_left, scan_last, conv_valid} = 5'h00;
    {conversion_done_irq_enable, done_clear, watchdog_clear} = 3'h0;
    {read_low_strobe, read_high_strobe, buffer_depth, watchdog_irq_enable} = 4'h3;
    {status_clear, watchdog_channel_enable} = 20'h00004;
    {high_threshold, low_threshold, conv_data} = 30'h30010000;
    {conv_index, read_index} = 8'h00;
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    t_buf();
    t_scan();
    t_align();
    give_verdict();
  end
endmodule // tb_top
bind afw_flag_align afw_flag_align_properties u_afw_flag_align_properties (.mclk,
  .sys_rst, .buffered_mode, .scan_mode, .buffer_depth, .align_left,
  .conversion_done_irq_enable, .watchdog_irq_enable, .conv_valid, .conv_index, .scan_last,
  .read_low_strobe, .read_high_strobe, .result_high_byte, .conversion_done_flag,
  .global_watchdog_flag, .channel_watchdog_status, .stop_conversion, .irq_request,
  .wake_from_wait, .wake_from_halt);
`default_nettype wire
